// ### logic/nand_host_regs.vh
/*
  Constants for the NAND flash host port: command codes, address layout and timing counts.
  Assumes a 40 MHz clock (25 ns period); included by the host port modules.
*/
`ifndef NAND_HOST_REGS_VH
`define NAND_HOST_REGS_VH

// Command codes written into the device command register.
`define CMD_READ_FIRST 8'h00
`define CMD_READ_SECOND 8'h01
`define CMD_PAGE_PROG 8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_BLOCK_ERASE 8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_READ_STATUS 8'h70
`define CMD_RESET 8'hFF

// Operation codes on the user side.
`define OP_READ 3'h0
`define OP_PROG 3'h1
`define OP_ERASE 3'h2
`define OP_STATUS 3'h3
`define OP_RESET 3'h4

// Address layout: 26 bit byte address, column bits 7:0, half select bit 8.
`define ADDR_W 26
`define HALF_BIT 8
`define ROW_LSB 9
`define PAGE_BYTES 10'h210

// Strobe timing in ns and derived cycle counts (minimum times, rounded up).
`define CLK_PERIOD_NS 25
`define T_STROBE_LOW_NS 25
`define T_STROBE_HIGH_NS 25
`define T_OUT_ACCESS_NS 35
`define T_BUSY_SETTLE_NS 100
`define STROBE_LOW_CYC ((`T_STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`T_STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUT_ACCESS_CYC ((`T_OUT_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_SETTLE_CYC ((`T_BUSY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### logic/strobe_timer.v
/*
  Down counter that times strobe phases of the flash port.
  Assumes a load pulse with a nonzero count; done is high when the count has run out.
*/
`timescale 1ns/1ps
`default_nettype none

module strobe_timer (
  input wire mclk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [3:0] count_i,
  output wire done_o
);

  reg [3:0] cnt_r;

  // Load the phase length, then count down to zero.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign done_o = (cnt_r == 4'h0) && !load_i;

endmodule // strobe_timer

`default_nettype wire

// ### logic/nand_flash_host_port.v
/*
  Host controller that drives an 8-bit asynchronous NAND flash through its pins.
  Assumes the device pins are wired directly; bus and busy inputs are synchronous to mclk_i.
*/
// Overview of operation
// - Shared 8-bit bus carries commands, addresses, write data out and read data in.
// - Host raises command latch with command byte before write strobe rising edge.
// - Host raises address latch with address byte before write strobe rising edge.
// - Host holds each byte stable across the write strobe rising edge.
// - Address takes four cycles: column, A9-A16, A17-A24, A25 on bit 0.
// - Host drives bus bits 1 to 7 low in fourth address cycle.
// - Host keeps chip select low while pulsing write strobe for each byte.
// - Block erase sends only three row address cycles, no column cycle.
// - Commands 80h program, 60h erase, 70h status, FFh reset.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.vh"

module nand_flash_host_port (
  input wire mclk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [2:0] op_i,
  input wire [25:0] addr_i,
  input wire [9:0] len_i,
  input wire [7:0] wdata_i,
  input wire wp_allow_i,
  output reg wdata_ack_o,
  output reg [7:0] rdata_o,
  output reg rdata_valid_o,
  output reg busy_o,
  output reg done_o,
  input wire [7:0] io_in_i,
  output reg [7:0] io_out_o,
  output reg io_oe_o,
  output reg cle_o,
  output reg ale_o,
  output reg chip_sel_n_o,
  output reg write_strobe_n_o,
  output reg output_strobe_n_o,
  output reg prog_lock_n_o,
  input wire ready_i
);

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_CMD = 8'h02;
  localparam [7:0] S_ADDR = 8'h04;
  localparam [7:0] S_WDATA = 8'h08;
  localparam [7:0] S_CONF = 8'h10;
  localparam [7:0] S_WAIT = 8'h20;
  localparam [7:0] S_RDATA = 8'h40;
  localparam [7:0] S_DONE = 8'h80;
  // Cycle counts are worked out as integers, then cut to the timer width on purpose.
  localparam integer LOW_INT = `STROBE_LOW_CYC;
  localparam integer HIGH_INT = `STROBE_HIGH_CYC;
  localparam integer ACC_INT = `OUT_ACCESS_CYC + 1;
  localparam integer SETTLE_INT = `BUSY_SETTLE_CYC;
  localparam [3:0] LOW_CYC = LOW_INT[3:0];
  localparam [3:0] HIGH_CYC = HIGH_INT[3:0];
  localparam [3:0] ACC_CYC = ACC_INT[3:0];
  localparam [3:0] SETTLE_CYC = SETTLE_INT[3:0];

  reg [7:0] state_r;
  reg [2:0] op_r;
  reg [25:0] addr_r;
  reg [9:0] left_r;
  reg [1:0] acyc_r;
  reg phase_r;
  reg sampled_r;
  reg tload_r;
  reg [3:0] tcount_r;
  wire tdone;

  // Picks one address byte out of the latched address for a given cycle.
  function [7:0] addr_byte;
    input [25:0] a;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: addr_byte = a[7:0];
        2'h1: addr_byte = a[`ROW_LSB+7:`ROW_LSB];
        2'h2: addr_byte = a[`ROW_LSB+15:`ROW_LSB+8];
        default: addr_byte = {7'h00, a[`ADDR_W-1]};
      endcase
    end
  endfunction

  // Command byte that opens each operation; half select picks 00h or 01h.
  function [7:0] first_cmd;
    input [2:0] op;
    input half;
    begin
      case (op)
        `OP_READ: first_cmd = half ? `CMD_READ_SECOND : `CMD_READ_FIRST;
        `OP_PROG: first_cmd = `CMD_PAGE_PROG;
        `OP_ERASE: first_cmd = `CMD_BLOCK_ERASE;
        `OP_STATUS: first_cmd = `CMD_READ_STATUS;
        default: first_cmd = `CMD_RESET;
      endcase
    end
  endfunction

  strobe_timer u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(tload_r),
    .count_i(tcount_r),
    .done_o(tdone)
  );

  // Sequencer: each byte is one low phase and one high phase of a strobe.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      op_r <= 3'h0;
      addr_r <= 26'h0;
      left_r <= 10'h0;
      acyc_r <= 2'h0;
      phase_r <= 1'b0;
      sampled_r <= 1'b0;
      tload_r <= 1'b0;
      tcount_r <= 4'h0;
      wdata_ack_o <= 1'b0;
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      io_out_o <= 8'h00;
      io_oe_o <= 1'b0;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      chip_sel_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      output_strobe_n_o <= 1'b1;
      prog_lock_n_o <= 1'b0;
    end else begin
      tload_r <= 1'b0;
      wdata_ack_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      done_o <= 1'b0;
      prog_lock_n_o <= wp_allow_i;
      case (state_r)
        S_IDLE: begin
          chip_sel_n_o <= 1'b1;
          io_oe_o <= 1'b0;
          if (start_i && ready_i) begin
            op_r <= op_i;
            addr_r <= addr_i;
            left_r <= (len_i > `PAGE_BYTES) ? `PAGE_BYTES : len_i;
            busy_o <= 1'b1;
            phase_r <= 1'b0;
            chip_sel_n_o <= 1'b0;
            state_r <= S_CMD;
          end
        end
        S_CMD, S_ADDR, S_WDATA, S_CONF: begin
          if (!phase_r) begin
            // Drive latch enables and byte and pull the write strobe low in the same cycle.
            chip_sel_n_o <= 1'b0;
            io_oe_o <= 1'b1;
            cle_o <= (state_r == S_CMD) || (state_r == S_CONF);
            ale_o <= (state_r == S_ADDR);
            if (state_r == S_CMD) begin
              io_out_o <= first_cmd(op_r, addr_r[`HALF_BIT]);
            end else if (state_r == S_ADDR) begin
              io_out_o <= addr_byte(addr_r, acyc_r);
            end else if (state_r == S_WDATA) begin
              io_out_o <= wdata_i;
              wdata_ack_o <= 1'b1;
            end else begin
              io_out_o <= (op_r == `OP_PROG) ? `CMD_PROG_CONFIRM : `CMD_ERASE_CONFIRM;
            end
            write_strobe_n_o <= 1'b0;
            tcount_r <= LOW_CYC;
            tload_r <= 1'b1;
            phase_r <= 1'b1;
          end else if (tdone && !write_strobe_n_o) begin
            // Rising edge latches the byte; bus and enables stay through the high phase.
            write_strobe_n_o <= 1'b1;
            tcount_r <= HIGH_CYC;
            tload_r <= 1'b1;
          end else if (tdone && write_strobe_n_o) begin
            phase_r <= 1'b0;
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            case (state_r)
              S_CMD: begin
                acyc_r <= (op_r == `OP_ERASE) ? 2'h1 : 2'h0;
                if (op_r == `OP_STATUS) begin
                  left_r <= 10'h1;
                  state_r <= S_RDATA;
                end else if (op_r == `OP_RESET) begin
                  state_r <= S_WAIT;
                end else begin
                  state_r <= S_ADDR;
                end
              end
              S_ADDR: begin
                acyc_r <= acyc_r + 2'h1;
                if (acyc_r == 2'h3) begin
                  if (op_r == `OP_PROG) begin
                    state_r <= (left_r == 10'h0) ? S_CONF : S_WDATA;
                  end else if (op_r == `OP_ERASE) begin
                    state_r <= S_CONF;
                  end else begin
                    state_r <= S_WAIT;
                  end
                end
              end
              S_WDATA: begin
                left_r <= left_r - 10'h1;
                if (left_r == 10'h1) begin
                  state_r <= S_CONF;
                end
              end
              default: begin
                state_r <= S_WAIT;
              end
            endcase
            if (state_r != S_CMD && state_r != S_ADDR && state_r != S_WDATA) begin
              tcount_r <= SETTLE_CYC;
              tload_r <= 1'b1;
            end else if (state_r == S_ADDR && acyc_r == 2'h3 && op_r == `OP_READ) begin
              tcount_r <= SETTLE_CYC;
              tload_r <= 1'b1;
            end else if (state_r == S_CMD && op_r == `OP_RESET) begin
              tcount_r <= SETTLE_CYC;
              tload_r <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          // Wait out the busy settle time, then for ready to return high.
          io_oe_o <= 1'b0;
          if (tdone && ready_i) begin
            if (op_r == `OP_READ && left_r != 10'h0) begin
              state_r <= S_RDATA;
            end else begin
              state_r <= S_DONE;
            end
          end
        end
        S_RDATA: begin
          // Falling read strobe brings the next byte; sample after access time.
          io_oe_o <= 1'b0;
          if (!phase_r) begin
            output_strobe_n_o <= 1'b0;
            tcount_r <= ACC_CYC;
            tload_r <= 1'b1;
            phase_r <= 1'b1;
            sampled_r <= 1'b0;
          end else if (tdone && !sampled_r) begin
            rdata_o <= io_in_i;
            rdata_valid_o <= 1'b1;
            output_strobe_n_o <= 1'b1;
            sampled_r <= 1'b1;
            tcount_r <= HIGH_CYC;
            tload_r <= 1'b1;
          end else if (tdone && sampled_r) begin
            phase_r <= 1'b0;
            left_r <= left_r - 10'h1;
            if (left_r == 10'h1) begin
              state_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          chip_sel_n_o <= 1'b1;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // nand_flash_host_port

`default_nettype wire

// ### sim/nand_host_port_properties.sv
/* Assertions on the pins of the NAND flash host port.
   Assumes it is bound to nand_flash_host_port and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module nand_host_port_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire wp_allow_i,
  input wire [7:0] io_in_i,
  input wire ready_i,
  input wire [7:0] rdata_o,
  input wire rdata_valid_o,
  input wire busy_o,
  input wire [7:0] io_out_o,
  input wire io_oe_o,
  input wire cle_o,
  input wire ale_o,
  input wire chip_sel_n_o,
  input wire write_strobe_n_o,
  input wire output_strobe_n_o,
  input wire prog_lock_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Write side: select, bus drive and a stable byte across the strobe edge.
  property p_we_sel; !write_strobe_n_o |-> !chip_sel_n_o; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write strobe without select");
  property p_we_drive; $fell(write_strobe_n_o) |-> io_oe_o; endproperty
  a_we_drive: assert property (p_we_drive) else $error("write strobe with bus idle");
  property p_hold; $rose(write_strobe_n_o) |-> io_oe_o && $stable(io_out_o) && $stable(cle_o) && $stable(ale_o); endproperty
  a_hold: assert property (p_hold) else $error("byte moved at strobe edge");
  property p_latch; !(cle_o && ale_o); endproperty
  a_latch: assert property (p_latch) else $error("both latch enables high");
  // Read side: no bus fight, strobe shape and captured byte.
  property p_no_fight; io_oe_o |-> output_strobe_n_o; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus driven during read strobe");
  property p_read; $fell(output_strobe_n_o) |-> !output_strobe_n_o [*5] ##1 (output_strobe_n_o && rdata_valid_o); endproperty
  a_read: assert property (p_read) else $error("read strobe shape wrong");
  property p_rdata; rdata_valid_o |-> rdata_o == $past(io_in_i); endproperty
  a_rdata: assert property (p_rdata) else $error("read byte not from bus");
  // Lock follows its enable; operations start only on a ready device.
  property p_lock; $past(rst_n_i) |-> prog_lock_n_o == $past(wp_allow_i); endproperty
  a_lock: assert property (p_lock) else $error("lock does not follow enable");
  property p_accept; $rose(busy_o) |-> $past(ready_i) && $past(start_i); endproperty
  a_accept: assert property (p_accept) else $error("start taken while device busy");
endmodule // nand_host_port_chk
bind nand_flash_host_port nand_host_port_chk chk (.mclk_i, .rst_n_i, .start_i, .wp_allow_i, .io_in_i, .ready_i,
  .rdata_o, .rdata_valid_o, .busy_o, .io_out_o, .io_oe_o, .cle_o, .ale_o, .chip_sel_n_o, .write_strobe_n_o,
  .output_strobe_n_o, .prog_lock_n_o);
`default_nettype wire

// ### sim/nand_dev_model.sv
/* Behavioural model of the flash device on the far side of the host port.
   Assumes the bench resolves the shared bus; the model drives the ready line itself. */
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(parameter int T_OUT_ACCESS = 35, parameter int T_BUSY = 300) (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic lock_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  output logic ready_o
);
  logic [7:0] cmd = 8'h00, first_cmd = 8'h00, dlast = 8'h00;
  logic [7:0] addr [0:3];
  logic [9:0] col = 10'h000;
  logic half = 1'b0, took = 1'b0;
  int n_addr = 0, n_data = 0;
  event go;
  initial dq_o = 8'h00;
  initial dq_oe_o = 1'b0;
  // Busy ends by time alone; chip select has no say in it.
  always @(go) begin
    ready_o = 1'b0;
    #T_BUSY;
    ready_o = 1'b1;
  end
  initial ready_o = 1'b1;
  // Bytes are taken on the rising write strobe edge while selected.
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      cmd = dq_i;
      if (dq_i == 8'h00 || dq_i == 8'h01) half = dq_i[0];
      if (dq_i == 8'h10 || dq_i == 8'hD0) begin
        took = lock_n_i;
        -> go;
      end else begin
        first_cmd = dq_i;
        n_addr = 0;
        n_data = 0;
      end
    end else if (ale_i) begin
      if (n_addr < 4) addr[n_addr] = dq_i;
      n_addr++;
      if (n_addr == 4 && first_cmd[7:1] == 7'h00) begin
        col = {1'b0, half, addr[0]};
        half = 1'b0;
        -> go;
      end
    end else begin
      n_data++;
      dlast = dq_i;
    end
  end
  // Each read strobe fall puts the next byte out after the access delay.
  always @(negedge re_n_i) if (!ce_n_i) begin
    #T_OUT_ACCESS;
    dq_o = (cmd == 8'h70) ? {lock_n_i, 7'h40} : col[7:0] ^ (col[8] ? 8'hA5 : 8'h5A);
    dq_oe_o = 1'b1;
    col++;
  end
  // Drivers let go when the strobe ends or the device is deselected.
  always @(posedge re_n_i or posedge ce_n_i) dq_oe_o = 1'b0;
endmodule // nand_dev_model
`default_nettype wire

// ### sim/nand_flash_host_port_tb.sv
/* Self-checking bench for the NAND flash host port with a device model.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_regs.vh"
module nand_flash_host_port_tb;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, wp_allow_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [25:0] addr_i = 26'h0000000;
  logic [9:0] len_i = 10'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, io_out_o, io_in_i, dq;
  logic wdata_ack_o, rdata_valid_o, busy_o, done_o, io_oe_o, cle_o, ale_o, dq_oe, ready_i;
  logic chip_sel_n_o, write_strobe_n_o, output_strobe_n_o, prog_lock_n_o;
  logic [7:0] rd [0:7];
  logic [9:0] c;
  int nrd = 0, error_cnt = 0, checks = 0;
  nand_flash_host_port uut (.mclk_i, .rst_n_i, .start_i, .op_i, .addr_i, .len_i, .wdata_i, .wp_allow_i,
    .wdata_ack_o, .rdata_o, .rdata_valid_o, .busy_o, .done_o, .io_in_i, .io_out_o, .io_oe_o, .cle_o, .ale_o,
    .chip_sel_n_o, .write_strobe_n_o, .output_strobe_n_o, .prog_lock_n_o, .ready_i);
  nand_dev_model dev (.ce_n_i(chip_sel_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(write_strobe_n_o),
    .re_n_i(output_strobe_n_o), .lock_n_i(prog_lock_n_o), .dq_i(io_in_i), .dq_o(dq), .dq_oe_o(dq_oe),
    .ready_o(ready_i));
  // Shared bus level; a released bus shows the inverse of the device's last byte.
  assign io_in_i = io_oe_o ? io_out_o : (dq_oe ? dq : ~dq);
  initial forever #12.5 mclk_i = ~mclk_i;
  // Next write byte is offered once the current one is taken.
  always @(posedge mclk_i) if (wdata_ack_o === 1'b1) wdata_i <= wdata_i + 8'h01;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Starts one operation and gathers read bytes until done, within a bound.
  task automatic run(input logic [2:0] op, input logic [25:0] a, input logic [9:0] n);
    int k;
    nrd = 0;
    @(posedge mclk_i);
    op_i <= op;
    addr_i <= a;
    len_i <= n;
    wdata_i <= 8'h30;
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (k = 0; k < 4000 && done_o !== 1'b1; k++) begin
      @(posedge mclk_i);
      #1;
      if (rdata_valid_o === 1'b1 && nrd < 8) rd[nrd++] = rdata_o;
    end
    if (k == 4000) begin
      error_cnt++;
      $display("MISMATCH done expected 1 seen timeout");
      complete_run();
    end
    chk("busy after done", 0, busy_o);
  endtask
  task automatic t_read;
    run(`OP_READ, {1'b1, 8'h3C, 8'hC3, 1'b1, 8'hFD}, 10'h003);
    chk("read count", 3, nrd);
    for (int i = 0; i < 3; i++) begin
      c = 10'h1FD + i;
      chk("read byte", c[7:0] ^ (c[8] ? 8'hA5 : 8'h5A), rd[i]);
    end
    chk("read cmd", 8'h01, dev.first_cmd);
    chk("addr cycles", 4, dev.n_addr);
    chk("row low", 8'hC3, dev.addr[1]);
    chk("row high", 8'h3C, dev.addr[2]);
    chk("top row", 8'h01, dev.addr[3]);
    $display("read test done");
  endtask
  task automatic t_prog;
    @(posedge mclk_i);
    wp_allow_i <= 1'b1;
    run(`OP_PROG, {1'b0, 8'h12, 8'h34, 1'b0, 8'h07}, 10'h005);
    chk("prog cmd", 8'h80, dev.first_cmd);
    chk("prog confirm", 8'h10, dev.cmd);
    chk("prog addr", 4, dev.n_addr);
    chk("data count", 5, dev.n_data);
    chk("last data", 8'h34, dev.dlast);
    chk("prog taken", 1, dev.took);
    $display("program test done");
  endtask
  task automatic t_erase;
    @(posedge mclk_i);
    wp_allow_i <= 1'b0;
    run(`OP_ERASE, {1'b1, 8'h55, 8'hAA, 1'b0, 8'h00}, 10'h000);
    chk("erase cmd", 8'h60, dev.first_cmd);
    chk("erase confirm", 8'hD0, dev.cmd);
    chk("erase addr", 3, dev.n_addr);
    chk("erase row", 8'hAA, dev.addr[0]);
    chk("erase locked", 0, dev.took);
    $display("erase test done");
  endtask
  task automatic t_status_reset;
    run(`OP_STATUS, 26'h0000000, 10'h000);
    chk("status cmd", 8'h70, dev.cmd);
    chk("status byte", 8'h40, rd[0]);
    run(`OP_RESET, 26'h0000000, 10'h000);
    chk("reset cmd", 8'hFF, dev.cmd);
    $display("status and reset test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_read();
    t_prog();
    t_erase();
    t_status_reset();
    complete_run();
  end
endmodule // nand_flash_host_port_tb
`default_nettype wire
